/* File: design/rsp_defs.svh */
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH

// =====================================================================
// link constants
`define RSP_SLV_ADDR    7'h51
`define RSP_RW_BIT      0
`define RSP_READ_VAL    1'h1
`define RSP_BYTE_BITS   4'h8
`define RSP_LAST_TX_BIT 4'h7
`define RSP_LINK_CLK_NS 320

`endif

/* File: design/rsp_pkg.sv */
// =====================================================================
// types of the serial slave port
package rsp_pkg;

  // gray along idle, receive, ack, transmit, master ack, wait
  typedef enum logic [2:0] {
    RSP_IDLE   = 3'h0,
    RSP_RX     = 3'h1,
    RSP_RX_ACK = 3'h3,
    RSP_TX     = 3'h2,
    RSP_TX_ACK = 3'h6,
    RSP_WAIT   = 3'h7
  } rsp_state_t;

  // phase of the byte being received
  typedef enum logic [1:0] {
    RSP_PH_ADDR = 2'h0,
    RSP_PH_PTR  = 2'h1,
    RSP_PH_DATA = 2'h3
  } rsp_phase_t;

endpackage : rsp_pkg

/* File: design/rsp_i2c_slave.sv */
`timescale 1ns/10ps
`include "rsp_defs.svh"

module rsp_i2c_slave #(
  parameter logic [6:0] SLV_ADDR = `RSP_SLV_ADDR,
  parameter int         PTR_W    = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // two-wire link
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  // internal register file side
  output logic [PTR_W-1:0]      reg_addr_o,
  output logic [7:0]            reg_wdata_o,
  output logic                  reg_we_o,
  output logic                  reg_re_o,
  input  wire logic [7:0]       reg_rdata_i,
  // status
  output logic                  busy_o
);

  // =====================================================================
  // parameter check, refused at elaboration
  if (PTR_W < 1 || PTR_W > 8) begin : g_bad_ptr_w
    $error("PTR_W must lie between 1 and 8");
  end

  // =====================================================================
  // input synchronisers and edge detect
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s1_ff <= 1'h1;
      scl_s2_ff <= 1'h1;
      scl_d_ff  <= 1'h1;
      sda_s1_ff <= 1'h1;
      sda_s2_ff <= 1'h1;
      sda_d_ff  <= 1'h1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff  <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff  <= sda_s2_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;

  // line events, all from the second synchroniser stage
  assign scl_rise  = scl_s2_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s2_ff & scl_d_ff;
  assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_det  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

  // =====================================================================
  // protocol state
  rsp_pkg::rsp_state_t state_ff, nxt_state;
  rsp_pkg::rsp_phase_t phase_ff, nxt_phase;
  logic [3:0]          cnt_ff, nxt_cnt;
  logic [7:0]          shift_ff, nxt_shift;
  logic                rd_ff, nxt_rd;
  logic                macked_ff, nxt_macked;
  logic                oe_ff, nxt_oe;
  logic [PTR_W-1:0]    ptr_ff, nxt_ptr;
  logic [7:0]          wdata_ff, nxt_wdata;
  logic                we_ff, nxt_we;
  logic                re_ff, nxt_re;
  logic                busy_ff, nxt_busy;

  // next-state logic
  always_comb begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff;
    nxt_cnt    = cnt_ff;
    nxt_shift  = shift_ff;
    nxt_rd     = rd_ff;
    nxt_macked = macked_ff;
    nxt_oe     = oe_ff;
    nxt_ptr    = ptr_ff;
    nxt_wdata  = wdata_ff;
    nxt_we     = 1'h0;
    nxt_re     = 1'h0;
    if (start_det) begin
      // start or repeated start: listen for the address
      nxt_state = rsp_pkg::RSP_RX;
      nxt_phase = rsp_pkg::RSP_PH_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'h0;
    end else if (stop_det) begin
      nxt_state = rsp_pkg::RSP_IDLE;
      nxt_oe    = 1'h0;
    end else begin
      case (state_ff)
        rsp_pkg::RSP_IDLE: begin
          nxt_oe = 1'h0;
        end
        rsp_pkg::RSP_RX: begin
          if (scl_rise && cnt_ff != `RSP_BYTE_BITS) begin
            // sample while clock high, msb first
            nxt_shift = {shift_ff[6:0], sda_s2_ff};
            nxt_cnt   = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `RSP_BYTE_BITS) begin
            nxt_cnt = 4'h0;
            case (phase_ff)
              rsp_pkg::RSP_PH_ADDR: begin
                if (shift_ff[7:1] == SLV_ADDR) begin
                  nxt_rd    = (shift_ff[`RSP_RW_BIT] == `RSP_READ_VAL);
                  nxt_oe    = 1'h1;
                  nxt_state = rsp_pkg::RSP_RX_ACK;
                end else begin
                  // other address, including test ones: stay off the bus
                  nxt_state = rsp_pkg::RSP_IDLE;
                end
              end
              rsp_pkg::RSP_PH_PTR: begin
                nxt_ptr   = shift_ff[PTR_W-1:0];
                nxt_phase = rsp_pkg::RSP_PH_DATA;
                nxt_oe    = 1'h1;
                nxt_state = rsp_pkg::RSP_RX_ACK;
              end
              default: begin
                // store at pointer, then advance
                nxt_wdata = shift_ff;
                nxt_we    = 1'h1;
                nxt_oe    = 1'h1;
                nxt_state = rsp_pkg::RSP_RX_ACK;
              end
            endcase
          end
        end
        rsp_pkg::RSP_RX_ACK: begin
          if (we_ff) begin
            nxt_ptr = ptr_ff + PTR_W'(1);
          end
          if (scl_fall) begin
            // let go after the ninth clock
            nxt_oe = 1'h0;
            if (phase_ff == rsp_pkg::RSP_PH_ADDR && rd_ff) begin
              // simplified read from the current pointer
              nxt_shift = reg_rdata_i;
              nxt_re    = 1'h1;
              nxt_oe    = ~reg_rdata_i[7];
              nxt_cnt   = 4'h0;
              nxt_state = rsp_pkg::RSP_TX;
            end else begin
              if (phase_ff == rsp_pkg::RSP_PH_ADDR) begin
                nxt_phase = rsp_pkg::RSP_PH_PTR;
              end
              nxt_state = rsp_pkg::RSP_RX;
            end
          end
        end
        rsp_pkg::RSP_TX: begin
          if (scl_fall) begin
            if (cnt_ff == `RSP_LAST_TX_BIT) begin
              // release for the master's acknowledge
              nxt_oe     = 1'h0;
              nxt_ptr    = ptr_ff + PTR_W'(1);
              nxt_macked = 1'h0;
              nxt_state  = rsp_pkg::RSP_TX_ACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'h0};
              nxt_oe    = ~shift_ff[6];
              nxt_cnt   = cnt_ff + 4'h1;
            end
          end
        end
        rsp_pkg::RSP_TX_ACK: begin
          nxt_oe = 1'h0;
          if (scl_rise) begin
            if (!sda_s2_ff) begin
              nxt_macked = 1'h1;
            end else begin
              nxt_state = rsp_pkg::RSP_WAIT;
            end
          end else if (scl_fall && macked_ff) begin
            // next byte, no end to the stream
            nxt_shift = reg_rdata_i;
            nxt_re    = 1'h1;
            nxt_oe    = ~reg_rdata_i[7];
            nxt_cnt   = 4'h0;
            nxt_state = rsp_pkg::RSP_TX;
          end
        end
        rsp_pkg::RSP_WAIT: begin
          nxt_oe = 1'h0;
        end
        default: begin
          nxt_state = rsp_pkg::RSP_IDLE;
          nxt_oe    = 1'h0;
        end
      endcase
    end
    // busy follows the state, registered so the output comes from a flop
    nxt_busy = (nxt_state != rsp_pkg::RSP_IDLE);
  end

  // state registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff  <= rsp_pkg::RSP_IDLE;
      phase_ff  <= rsp_pkg::RSP_PH_ADDR;
      cnt_ff    <= 4'h0;
      shift_ff  <= 8'h00;
      rd_ff     <= 1'h0;
      macked_ff <= 1'h0;
      oe_ff     <= 1'h0;
      ptr_ff    <= '0;
      wdata_ff  <= 8'h00;
      we_ff     <= 1'h0;
      re_ff     <= 1'h0;
      busy_ff   <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      cnt_ff    <= nxt_cnt;
      shift_ff  <= nxt_shift;
      rd_ff     <= nxt_rd;
      macked_ff <= nxt_macked;
      oe_ff     <= nxt_oe;
      ptr_ff    <= nxt_ptr;
      wdata_ff  <= nxt_wdata;
      we_ff     <= nxt_we;
      re_ff     <= nxt_re;
      busy_ff   <= nxt_busy;
    end
  end

  // =====================================================================
  // outputs, open drain: only ever pulls low
  logic sda_zero_ff;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sda_zero_ff <= 1'h0;
    end else begin
      sda_zero_ff <= 1'h0;
    end
  end

  assign sda_o       = sda_zero_ff;
  assign sda_oe_o    = oe_ff;
  assign reg_addr_o  = ptr_ff;
  assign reg_wdata_o = wdata_ff;
  assign reg_we_o    = we_ff;
  assign reg_re_o    = re_ff;
  assign busy_o      = busy_ff;

endmodule : rsp_i2c_slave

/* File: bench/rsp_i2c_slave_props.sv */
`timescale 1ns/10ps
// =====================================================
// link checker
module rsp_i2c_slave_props #(
  parameter int PTR_W = 8
) (
  // watched ports
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  input wire logic             scl_i,
  input wire logic             sda_i,
  input wire logic             sda_o,
  input wire logic             sda_oe_o,
  input wire logic [PTR_W-1:0] reg_addr_o,
  input wire logic [7:0]       reg_wdata_o,
  input wire logic             reg_we_o,
  input wire logic             reg_re_o,
  input wire logic [7:0]       reg_rdata_i,
  input wire logic             busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // wire behaviour
  property p_ack_low; sda_oe_o |-> !sda_o; endproperty
  property p_chg_low; $changed(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
  property p_start; scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] busy_o; endproperty
  property p_stop; scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !busy_o; endproperty
  property p_quiet; !busy_o |-> !sda_oe_o; endproperty
  a_ack_low: assert property (p_ack_low) else $error("drive not low");
  a_chg_low: assert property (p_chg_low) else $error("data moved with clock high");
  a_start: assert property (p_start) else $error("start not taken");
  a_stop: assert property (p_stop) else $error("stop not taken");
  a_quiet: assert property (p_quiet) else $error("drive while idle");
  // register side
  property p_we_pulse; reg_we_o |=> !reg_we_o; endproperty
  property p_we_inc; reg_we_o |=> reg_addr_o == $past(reg_addr_o) + 1'h1; endproperty
  property p_xfer_busy; reg_we_o || reg_re_o |-> busy_o; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("store pulse too long");
  a_we_inc: assert property (p_we_inc) else $error("pointer not advanced");
  a_xfer_busy: assert property (p_xfer_busy) else $error("access while idle");
  property p_re_first; reg_re_o |-> sda_oe_o == !reg_rdata_i[7]; endproperty
  a_re_first: assert property (p_re_first) else $error("first read bit not msb of pointed register");
  c_we: cover property (reg_we_o);
  c_re: cover property (reg_re_o);
  c_ack: cover property ($rose(sda_oe_o) && busy_o);
endmodule : rsp_i2c_slave_props

bind rsp_i2c_slave rsp_i2c_slave_props #(.PTR_W(PTR_W)) u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_addr_o(reg_addr_o),
  .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o), .reg_rdata_i(reg_rdata_i),
  .busy_o(busy_o));

/* File: bench/rsp_bus_master.sv */
`timescale 1ns/10ps
// =====================================================
// two-wire bus master model
module rsp_bus_master (
  // clock and line
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // released bus at time zero
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // quarter of a 320 ns link bit
  task automatic q;
    repeat (2) @(posedge clk_i);
  endtask : q
  // start or repeated start
  task automatic start;
    sda_o <= 1'h1;
    q();
    scl_o <= 1'h1;
    q();
    sda_o <= 1'h0;
    q();
    scl_o <= 1'h0;
    q();
  endtask : start
  // stop, data rises while clock high
  task automatic stop;
    sda_o <= 1'h0;
    q();
    scl_o <= 1'h1;
    q();
    sda_o <= 1'h1;
    q();
    q();
  endtask : stop
  // nine bits msb first, last one is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_o <= tx[i];
      q();
      scl_o <= 1'h1;
      q();
      rx[i] = sda_i;
      q();
      scl_o <= 1'h0;
      q();
    end
  endtask : xfer
endmodule : rsp_bus_master

/* File: bench/test_rsp_i2c_slave.sv */
`timescale 1ns/10ps
`include "rsp_defs.svh"
// =====================================================
// bench top
module test_rsp_i2c_slave;
  logic       clk_i = 1'h0;
  logic       sys_rst_i = 1'h1;
  logic       scl_w, sda_m, sda_oe, we, re, busy;
  int         n_re = 0;
  logic [7:0] addr, wdata;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic [7:0] bad [4] = '{8'h92, 8'h95, 8'ha0, 8'ha5};
  logic [8:0] rx;
  logic [7:0] ptr;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  wire logic  sda_w = sda_m & ~sda_oe;
  // clock and register file
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (we) mem[addr] <= wdata;
  always @(posedge clk_i) if (re) n_re <= n_re + 1;
  rsp_i2c_slave u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we), .reg_re_o(re),
    .reg_rdata_i(mem[addr]), .busy_o(busy));
  rsp_bus_master u_mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_o(sda_m));
  // compare one nine-bit slot
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // byte the device must acknowledge
  task automatic put(input logic [7:0] d);
    u_mst.xfer({d, 1'h1}, rx);
    chk(rx, {d, 1'h0});
  endtask : put
  // write: pointer, then n bytes
  task automatic wr(input logic [7:0] p, input int n);
    u_mst.start();
    put({`RSP_SLV_ADDR, 1'h0});
    put(p);
    for (int i = 0; i < n; i++) begin
      exp_mem[8'(p + i)] = 8'($urandom);
      put(exp_mem[8'(p + i)]);
    end
  endtask : wr
  // read n bytes from the current pointer, expected to be p, last one not acknowledged
  task automatic rd(input logic [7:0] p, input int n);
    int r0;
    r0 = n_re;
    u_mst.start();
    put({`RSP_SLV_ADDR, 1'h1});
    for (int i = 0; i < n; i++) begin
      u_mst.xfer({8'hff, i == n - 1}, rx);
      chk(rx, {exp_mem[8'(p + i)], i == n - 1});
    end
    repeat (12) begin
      @(negedge clk_i);
      chk({7'h00, busy, sda_w}, 9'h003);
    end
    chk(9'(n_re - r0), 9'(n));
    @(posedge clk_i);
  endtask : rd
  // stop, then the device must be idle again
  task automatic fin;
    u_mst.stop();
    @(negedge clk_i);
    chk({8'h00, busy}, 9'h000);
    @(posedge clk_i);
  endtask : fin
  // verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    void'($urandom(32'hd3af3ef0));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      u_mst.start();
      u_mst.xfer({bad[k], 1'h1}, rx);
      chk(rx, {bad[k], 1'h1});
      fin();
    end
    wr(8'hfe, 4);
    fin();
    rd(8'h02, 2);
    fin();
    repeat (8) begin
      ptr = 8'($urandom);
      wr(ptr, 1 + $urandom % 5);
      wr(ptr, 0);
      rd(ptr, 1 + $urandom % 6);
      fin();
    end
    conclude();
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
endmodule : test_rsp_i2c_slave
